/* host_port_pkg.sv */
`default_nettype none
package host_port_pkg;
  // semaphore codes and upper-lane fill on reads
  localparam logic [7:0]  SEM_FREE        = 8'hfe;
  localparam logic [7:0]  SEM_BUSY        = 8'hff;
  localparam logic [7:0]  UPPER_FILL      = 8'hff;
  // register select on the two address inputs
  localparam logic [1:0]  SEL_COMMAND     = 2'h0;
  localparam logic [1:0]  SEL_VECTOR      = 2'h1;
  localparam logic [1:0]  SEL_DATA        = 2'h2;
  // reset values
  localparam logic [15:0] COMMAND_RESET   = 16'h0000;
  localparam logic [7:0]  VECTOR_RESET    = 8'h0f;
  localparam logic [15:0] DATA_RESET      = 16'h0000;
  localparam logic [15:0] DRIVE_RESET     = 16'h0000;

  typedef struct packed {
    logic        bus_8bit;
    logic        cs_n;
    logic        int_ack_n;
    logic        rw;
    logic        upper_strobe_or_a0;
    logic        lower_strobe_or_ds;
    logic [1:0]  addr;
    logic [15:0] data;
  } host_pins_t;

  typedef struct packed {
    logic [15:0] data;
    logic        oe_hi;
    logic        oe_lo;
    logic        ack_n;
    logic        ack_oe;
  } bus_drive_t;

  typedef enum {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_IGNORE,
    ST_INT_ACK_N,
    ST_RELEASE
  } port_state_t;
endpackage
`default_nettype wire

/* pin_sync.sv */
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_q;

  // pins idle high, so both stages reset to ones
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '1;
      q      <= '1;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* host_slave_bus_port.sv */
`default_nettype none
// Contract
// - chip select or int ack enters slave
// - address and strobes pick the register (reads ignore the address and return the semaphore byte on the lower lane only)
// - lower lane reads return the semaphore byte
// - upper lane reads drive all ones
// - read: select, direction high, drive, acknowledge
// - read held until strobes or select negate
// - semaphore is only fe or ff
// - only command, vector, data writable
// - write: decode, load, acknowledge
// - write ack negated then floated at end
// - byte chosen by strobes, or a0 and strobe on eight-bit bus
// - int ack with lower strobe drives vector
// - vector held until int ack/strobe negate
// - int ack while master flags address error
// - direction high means device drives bus
// - upper strobe high lane, lower low lane
// - eight-bit bus: a0 and single strobe
module host_slave_bus_port
  import host_port_pkg::*;
(
  input  wire logic                      core_clk,
  input  wire logic                      arst_n,
  input  wire host_port_pkg::host_pins_t pins,
  input  wire logic                      bus_master,
  input  wire logic                      sem_busy,
  output logic                    [15:0] host_data_out,
  output logic                           host_data_oe_hi,
  output logic                           host_data_oe_lo,
  output logic                           transfer_ack_n,
  output logic                           transfer_ack_oe,
  output logic                    [15:0] command_register,
  output logic                     [7:0] interrupt_vector_register,
  output logic                    [15:0] data_window_register,
  output logic                           command_written,
  output logic                           address_error
);
  import host_port_pkg::*;

  host_pins_t  pins_s;
  port_state_t st_q, st_d;
  bus_drive_t  drv_q, drv_d;
  logic [15:0] command_q, command_d;
  logic [7:0]  vector_q, vector_d;
  logic [15:0] data_q, data_d;
  logic        cmd_wr_q, cmd_wr_d;
  logic        addr_err_q, addr_err_d;
  logic        int_ack_n_seen_q, int_ack_n_seen_d;
  logic        upper_sel, lower_sel, any_strobe, strobes_idle;
  logic        read_start, write_start, int_ack_n_start;
  logic [7:0]  hi_byte, lo_byte, sem_byte;

  pin_sync #(.WIDTH($bits(host_pins_t))) u_pin_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .d        (pins),
    .q        (pins_s)
  );

  // lane decode from strobes, or from a0 and strobe on an eight-bit bus
  always_comb begin
    if (pins_s.bus_8bit) begin
      // a0 high is the odd byte, carried on the low lines
      lower_sel    = !pins_s.lower_strobe_or_ds
                     && pins_s.upper_strobe_or_a0;
      upper_sel    = !pins_s.lower_strobe_or_ds
                     && !pins_s.upper_strobe_or_a0;
      any_strobe   = !pins_s.lower_strobe_or_ds;
      strobes_idle = pins_s.lower_strobe_or_ds;
      hi_byte      = pins_s.data[7:0];
    end else begin
      upper_sel    = !pins_s.upper_strobe_or_a0;
      lower_sel    = !pins_s.lower_strobe_or_ds;
      any_strobe   = upper_sel || lower_sel;
      strobes_idle = !any_strobe;
      hi_byte      = pins_s.data[15:8];
    end
    lo_byte  = pins_s.data[7:0];
    sem_byte = sem_busy ? SEM_BUSY : SEM_FREE;
  end

  // select starts register cycles, int ack starts vector cycles
  assign read_start  = !pins_s.cs_n && pins_s.rw
                       && any_strobe;
  assign write_start = !pins_s.cs_n && !pins_s.rw
                       && any_strobe;
  assign int_ack_n_start  = pins_s.cs_n && !pins_s.int_ack_n
                       && !pins_s.lower_strobe_or_ds && !bus_master;

  always_comb begin
    st_d        = st_q;
    drv_d       = drv_q;
    command_d   = command_q;
    vector_d    = vector_q;
    data_d      = data_q;
    cmd_wr_d    = 1'b0;
    int_ack_n_seen_d = !pins_s.int_ack_n;
    addr_err_d  = !pins_s.int_ack_n && bus_master && !int_ack_n_seen_q;
    case (st_q)
      ST_IDLE: begin
        if (read_start) begin
          // address ignored: the semaphore is the only readable byte
          drv_d.data   = {UPPER_FILL, sem_byte};
          if (pins_s.bus_8bit) begin
            drv_d.data[7:0] = upper_sel ? UPPER_FILL : sem_byte;
            drv_d.oe_hi     = 1'b0;
            drv_d.oe_lo     = 1'b1;
          end else begin
            drv_d.oe_hi = upper_sel;
            drv_d.oe_lo = lower_sel;
          end
          drv_d.ack_n  = 1'b0;
          drv_d.ack_oe = 1'b1;
          st_d         = ST_READ;
        end else if (write_start) begin
          if (pins_s.addr == SEL_COMMAND || pins_s.addr == SEL_VECTOR
              || pins_s.addr == SEL_DATA) begin
            case (pins_s.addr)
              SEL_COMMAND: begin
                if (upper_sel) begin
                  command_d[15:8] = hi_byte;
                end
                if (lower_sel) begin
                  command_d[7:0] = lo_byte;
                end
                cmd_wr_d = 1'b1;
              end
              SEL_VECTOR: begin
                vector_d = lower_sel ? lo_byte : hi_byte;
              end
              default: begin
                if (upper_sel) begin
                  data_d[15:8] = hi_byte;
                end
                if (lower_sel) begin
                  data_d[7:0] = lo_byte;
                end
              end
            endcase
            drv_d.ack_n  = 1'b0;
            drv_d.ack_oe = 1'b1;
            st_d         = ST_WRITE;
          end else begin
            st_d = ST_IGNORE;
          end
        end else if (int_ack_n_start) begin
          drv_d.data[7:0] = vector_q;
          drv_d.oe_lo     = 1'b1;
          drv_d.ack_n     = 1'b0;
          drv_d.ack_oe    = 1'b1;
          st_d            = ST_INT_ACK_N;
        end
      end
      ST_READ, ST_WRITE: begin
        if (pins_s.cs_n || strobes_idle) begin
          drv_d.oe_hi = 1'b0;
          drv_d.oe_lo = 1'b0;
          drv_d.ack_n = 1'b1;
          st_d        = ST_RELEASE;
        end
      end
      ST_INT_ACK_N: begin
        if (pins_s.int_ack_n || pins_s.lower_strobe_or_ds) begin
          drv_d.oe_lo = 1'b0;
          drv_d.ack_n = 1'b1;
          st_d        = ST_RELEASE;
        end
      end
      ST_IGNORE: begin
        if (pins_s.cs_n || strobes_idle) begin
          st_d = ST_IDLE;
        end
      end
      ST_RELEASE: begin
        // ack was driven high for one cycle, now float it
        drv_d.ack_oe = 1'b0;
        st_d         = ST_IDLE;
      end
      default: begin
        st_d  = ST_IDLE;
        drv_d = '{DRIVE_RESET, 1'b0, 1'b0, 1'b1, 1'b0};
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q        <= ST_IDLE;
      drv_q       <= '{DRIVE_RESET, 1'b0, 1'b0, 1'b1, 1'b0};
      command_q   <= COMMAND_RESET;
      vector_q    <= VECTOR_RESET;
      data_q      <= DATA_RESET;
      cmd_wr_q    <= 1'b0;
      addr_err_q  <= 1'b0;
      int_ack_n_seen_q <= 1'b0;
    end else begin
      st_q        <= st_d;
      drv_q       <= drv_d;
      command_q   <= command_d;
      vector_q    <= vector_d;
      data_q      <= data_d;
      cmd_wr_q    <= cmd_wr_d;
      addr_err_q  <= addr_err_d;
      int_ack_n_seen_q <= int_ack_n_seen_d;
    end
  end

  assign host_data_out             = drv_q.data;
  assign host_data_oe_hi           = drv_q.oe_hi;
  assign host_data_oe_lo           = drv_q.oe_lo;
  assign transfer_ack_n            = drv_q.ack_n;
  assign transfer_ack_oe           = drv_q.ack_oe;
  assign command_register          = command_q;
  assign interrupt_vector_register = vector_q;
  assign data_window_register      = data_q;
  assign command_written           = cmd_wr_q;
  assign address_error             = addr_err_q;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  a_read_ack_start: assert property (
    st_q == ST_IDLE && read_start |=> st_q == ST_READ && !transfer_ack_n
      && transfer_ack_oe)
    else $error("read start not acknowledged");

  a_read_sem_value: assert property (
    st_q == ST_READ && drv_q.oe_lo && !pins_s.bus_8bit
      |-> drv_q.data[7:0] == SEM_FREE || drv_q.data[7:0] == SEM_BUSY)
    else $error("read byte is not a semaphore code");

  a_upper_fill: assert property (
    st_q == ST_READ && drv_q.oe_hi |-> drv_q.data[15:8] == UPPER_FILL)
    else $error("upper lane not all ones");

  a_read_hold: assert property (
    st_q == ST_READ && !pins_s.cs_n && !strobes_idle
      |=> !transfer_ack_n && $stable(drv_q.data))
    else $error("read outputs dropped early");

  a_ack_release: assert property (
    $rose(transfer_ack_n) |-> transfer_ack_oe ##1 !transfer_ack_oe)
    else $error("ack not driven high then floated");

  a_write_load: assert property (
    st_q == ST_IDLE && write_start && pins_s.addr == SEL_COMMAND
      && lower_sel && !pins_s.bus_8bit
      |=> command_q[7:0] == $past(pins_s.data[7:0]) && command_written)
    else $error("command low byte not loaded");

  a_unmapped_write: assert property (
    st_q == ST_IDLE && write_start && pins_s.addr == 2'h3
      |=> $stable(command_q) && $stable(vector_q) && $stable(data_q)
      && transfer_ack_n)
    else $error("unmapped write changed state");

  a_int_ack_n_vector: assert property (
    st_q == ST_IDLE && int_ack_n_start
      |=> drv_q.oe_lo && drv_q.data[7:0] == vector_q && !transfer_ack_n)
    else $error("vector not driven on int ack");

  a_int_ack_n_hold: assert property (
    st_q == ST_INT_ACK_N && !pins_s.int_ack_n && !pins_s.lower_strobe_or_ds
      |=> drv_q.oe_lo && !transfer_ack_n)
    else $error("vector released early");

  a_addr_error: assert property (
    $fell(pins_s.int_ack_n) && bus_master |=> address_error ##1 !address_error)
    else $error("address error not pulsed");

  c_read_cycle: cover property (
    st_q == ST_READ ##[1:20] st_q == ST_RELEASE);
  c_write_cycle: cover property (
    st_q == ST_WRITE ##[1:20] st_q == ST_RELEASE);
  c_int_ack_n_cycle: cover property (
    st_q == ST_INT_ACK_N ##[1:20] st_q == ST_RELEASE);
  c_addr_error: cover property (address_error);
endmodule
`default_nettype wire

/* host_model.sv */
`default_nettype none
module host_model
  import host_port_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 ack_n,
  input  wire logic                 ack_oe,
  input  wire logic                 oe_hi,
  input  wire logic                 oe_lo,
  input  wire logic [15:0]          rd,
  output var  host_port_pkg::host_pins_t pins
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    pins = {1'b0, 23'h7fffff};
  end

  // one cycle, held until acknowledged, then released whole
  task automatic xfer(input host_pins_t req, input int hold,
                      output logic [17:0] got, output logic ok,
                      output logic held, output logic neg);
    int n;
    @(posedge core_clk);
    #1 pins = req;
    ok = 1'b0;
    for (n = 0; n < 12 && !ok; n++) begin
      @(posedge core_clk);
      ok = (ack_n === 1'b0 && ack_oe === 1'b1);
    end
    got = {oe_hi, oe_lo, rd};
    repeat (hold) @(posedge core_clk);
    held = (ack_n === 1'b0);
    #1;
    // released bus must not keep the last value
    pins = {req.bus_8bit, 2'b11, req.rw, 2'b11, req.addr, ~req.data};
    neg = 1'b0;
    for (n = 0; n < 12 && ack_oe !== 1'b0; n++) begin
      @(posedge core_clk);
      if (ack_n === 1'b1 && ack_oe === 1'b1) neg = 1'b1;
    end
    @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`default_nettype none
`define CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_fail++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); \
  end \
end
module tb;
  import host_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic        bus_master = 1'b0;
  logic        sem_busy = 1'b0;
  logic        seen_err = 1'b0;
  logic        seen_cw = 1'b0;
  host_pins_t  pins;
  logic [15:0] dout, cmd, dwin;
  logic [7:0]  vec;
  logic        oe_hi, oe_lo, ack_n, ack_oe, cmd_wr, addr_err;
  logic [17:0] got;
  logic        ok, held, neg;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  host_slave_bus_port i_host_slave_bus_port (
    .core_clk(core_clk), .arst_n(arst_n), .pins(pins),
    .bus_master(bus_master), .sem_busy(sem_busy),
    .host_data_out(dout), .host_data_oe_hi(oe_hi),
    .host_data_oe_lo(oe_lo), .transfer_ack_n(ack_n),
    .transfer_ack_oe(ack_oe), .command_register(cmd),
    .interrupt_vector_register(vec), .data_window_register(dwin),
    .command_written(cmd_wr), .address_error(addr_err));
  host_model i_host_model (
    .core_clk(core_clk), .ack_n(ack_n), .ack_oe(ack_oe),
    .oe_hi(oe_hi), .oe_lo(oe_lo), .rd(dout), .pins(pins));

  function automatic host_pins_t rq(logic b8, logic cs_n, logic ia_n,
      logic rw, logic us, logic ls, logic [1:0] a, logic [15:0] d);
    return {b8, cs_n, ia_n, rw, us, ls, a, d};
  endfunction

  task automatic go(host_pins_t r, int hold);
    i_host_model.xfer(r, hold, got, ok, held, neg);
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic t_read();
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      #1 sem_busy = i[0];
      go(rq(0, 0, 1, 1, 0, 0, i[2:1], 16'h0), 2);
      `CHK(ok, 1'b1)
      `CHK(got, {2'b11, 8'hff, 7'h7f, i[0]})
      `CHK({held, neg}, 2'b11)
      `CHK({oe_hi, oe_lo}, 2'b00)
    end
    go(rq(0, 0, 1, 1, 1, 0, 2'h3, 16'h0), 0);
    `CHK({got[17:16], got[7:0]}, {2'b01, 8'hff})
    go(rq(0, 0, 1, 1, 0, 1, 2'h1, 16'h0), 0);
    `CHK(got[17:8], {2'b10, 8'hff})
    $display("test read done");
  endtask

  task automatic t_write();
    seen_cw = 1'b0;
    go(rq(0, 0, 1, 0, 0, 0, SEL_COMMAND, 16'h1234), 0);
    `CHK({ok, neg, cmd}, {2'b11, 16'h1234})
    `CHK(seen_cw, 1'b1)
    go(rq(0, 0, 1, 0, 1, 0, SEL_VECTOR, 16'h77a5), 0);
    `CHK(vec, 8'ha5)
    go(rq(0, 0, 1, 0, 0, 1, SEL_DATA, 16'hbeef), 0);
    `CHK(dwin, 16'hbe00)
    go(rq(0, 0, 1, 0, 1, 0, SEL_DATA, 16'h3377), 0);
    `CHK(dwin, 16'hbe77)
    go(rq(0, 0, 1, 0, 0, 0, 2'h3, 16'hdead), 0);
    `CHK({ok, cmd, vec, dwin}, {1'b0, 16'h1234, 8'ha5, 16'hbe77})
    $display("test write done");
  endtask

  task automatic t_8bit();
    go(rq(1, 0, 1, 0, 0, 0, SEL_DATA, 16'haa11), 0);
    go(rq(1, 0, 1, 0, 1, 0, SEL_DATA, 16'h5522), 0);
    `CHK(dwin, 16'h1122)
    @(posedge core_clk);
    #1 sem_busy = 1'b0;
    go(rq(1, 0, 1, 1, 0, 0, 2'h0, 16'h0), 0);
    `CHK({got[17:16], got[7:0]}, {2'b01, 8'hff})
    go(rq(1, 0, 1, 1, 1, 0, 2'h2, 16'h0), 0);
    `CHK({got[17:16], got[7:0]}, {2'b01, 8'hfe})
    $display("test 8bit done");
  endtask

  task automatic t_int_ack_n();
    seen_err = 1'b0;
    go(rq(0, 1, 0, 1, 1, 0, 2'h0, 16'h0), 2);
    `CHK(seen_err, 1'b0)
    `CHK({ok, got[17:16], got[7:0]}, {3'b101, 8'ha5})
    `CHK({held, neg}, 2'b11)
    @(posedge core_clk);
    #1 bus_master = 1'b1;
    seen_err = 1'b0;
    go(rq(0, 1, 0, 1, 1, 0, 2'h0, 16'h0), 0);
    `CHK({ok, seen_err}, 2'b01)
    repeat (2) @(posedge core_clk);
    #1 bus_master = 1'b0;
    $display("test int_ack_n done");
  endtask

  always #2 core_clk = ~core_clk;

  // sticky capture of one-cycle pulses, plus hang guard
  always @(posedge core_clk) begin
    cyc++;
    if (addr_err === 1'b1) seen_err = 1'b1;
    if (cmd_wr === 1'b1) seen_cw = 1'b1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end

  initial begin
    repeat (8) @(posedge core_clk);
    #1 arst_n = 1'b1;
    `CHK({vec, ack_n, ack_oe}, {VECTOR_RESET, 2'b10})
    `CHK({cmd, dwin}, {COMMAND_RESET, DATA_RESET})
    t_read();
    t_write();
    t_8bit();
    t_int_ack_n();
    summarize();
  end
endmodule
`default_nettype wire
